// ==== verif/tb_timer_counter_with_input_capture.sv ====
// Testbench: counter, prescaler, overflow, capture and external clock checks
`timescale 1ns/1ps
`default_nettype none
module tb_timer_counter_with_input_capture;
  typedef struct {logic [7:0] v; logic [7:0] tol;} tcic_note_type;
  logic          clk_sys       = 1'b0;
  logic          srst          = 1'b1;
  logic [5:0]    avs_address   = 6'h00;
  logic          avs_read      = 1'b0;
  logic          avs_write     = 1'b0;
  logic [31:0]   avs_writedata = 32'h0;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic          cpu_irq_mask  = 1'b0;
  logic          halt_mode     = 1'b1;
  logic          timer_irq;
  logic          cap1_lvl      = 1'b1;
  logic          cap2_lvl      = 1'b1;
  logic          ext_start     = 1'b0;
  logic [3:0]    ext_gap       = 4'h3;
  wire logic     capture_pin_1;
  wire logic     capture_pin_2;
  wire logic     ext_timer_clock_pin;
  wire logic     ext_busy;
  int            n_errors      = 0;
  int            tests_run     = 0;
  int            seed          = 50;
  tcic_note_type notes[$];
  tcic_note_type nt;

  always #2.5 clk_sys = ~clk_sys;

  tcic_timer dut (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capture_pin_1(capture_pin_1), .capture_pin_2(capture_pin_2),
    .ext_timer_clock_pin(ext_timer_clock_pin), .cpu_irq_mask(cpu_irq_mask),
    .halt_mode(halt_mode), .timer_irq(timer_irq));
  tcic_pin_model pins (.clk_sys(clk_sys), .cap1_lvl(cap1_lvl), .cap2_lvl(cap2_lvl),
    .ext_start(ext_start), .ext_gap(ext_gap), .capture_pin_1(capture_pin_1),
    .capture_pin_2(capture_pin_2), .ext_timer_clock_pin(ext_timer_clock_pin),
    .ext_busy(ext_busy));

  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic fail(input string m);
    n_errors++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail

  task automatic chk(input logic g, input logic e, input string m);
    tests_run++;
    if (g !== e) begin
      fail(m);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    int i;
    avs_address   <= a;
    avs_read      <= ~w;
    avs_write     <= w;
    avs_writedata <= {24'h0, d};
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (i == 16) begin
      fail("bus timeout");
      end_of_test();
    end
    @(posedge clk_sys);
  endtask : bus

  task automatic rd(input logic [5:0] a, input logic [7:0] v, input logic [7:0] tol);
    notes.push_back('{v, tol});
    bus(a, 1'b0, 8'h00);
  endtask : rd

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic pins_to(input logic a, input logic b);
    cap1_lvl <= a;
    cap2_lvl <= b;
    repeat (8) @(posedge clk_sys);
  endtask : pins_to

  task automatic run_for(input int n);
    halt_mode <= 1'b0;
    repeat (n) @(posedge clk_sys);
    halt_mode <= 1'b1;
    @(posedge clk_sys);
  endtask : run_for

  // Read data checker: oldest note against the answer at the accepting edge
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      tests_run++;
      if (notes.size() == 0) begin
        fail("read without note");
      end else begin
        nt = notes.pop_front();
        if (avs_readdata[31:8] !== 24'h0 || ((avs_readdata[7:0] - nt.v) <= nt.tol) !== 1'b1) begin
          fail("read data");
        end
      end
    end
  end

  initial begin
    logic [5:0] zl [8];
    int k;
    zl = '{tcic_pkg::ADDR_CTRL_ONE, tcic_pkg::ADDR_CTRL_TWO, tcic_pkg::ADDR_FLAGS,
      tcic_pkg::ADDR_CAP1_HI, tcic_pkg::ADDR_CAP1_LO, tcic_pkg::ADDR_CAP2_HI,
      tcic_pkg::ADDR_CAP2_LO, 6'h2C};
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(tcic_pkg::ADDR_CNT_HI, 8'hFF, 8'h00);
    rd(tcic_pkg::ADDR_CNT_LO, 8'hFC, 8'h00);
    rd(tcic_pkg::ADDR_ALT_LO, 8'hFC, 8'h00);
    foreach (zl[i]) rd(zl[i], 8'h00, 8'h00);
    $display("test reset values done");
    for (k = 0; k < 3; k++) begin
      wr(tcic_pkg::ADDR_CTRL_TWO, 8'(k << 2));
      wr(tcic_pkg::ADDR_CNT_LO, 8'($random(seed)));
      run_for(64);
      rd(tcic_pkg::ADDR_CNT_HI, 8'h00, 8'h00);
      rd(tcic_pkg::ADDR_CNT_LO, 8'(8'hFC + (64 >> (k + 1))), 8'h00);
    end
    $display("test prescaler done");
    wr(tcic_pkg::ADDR_CTRL_ONE, 8'h20);
    chk(timer_irq, 1'b1, "overflow irq");
    cpu_irq_mask <= 1'b1;
    @(posedge clk_sys);
    chk(timer_irq, 1'b0, "masked irq");
    cpu_irq_mask <= 1'b0;
    @(posedge clk_sys);
    chk(timer_irq, 1'b1, "pending irq");
    rd(tcic_pkg::ADDR_FLAGS, 8'h20, 8'h00);
    wr(tcic_pkg::ADDR_ALT_LO, 8'h00);
    rd(tcic_pkg::ADDR_FLAGS, 8'h20, 8'h00);
    wr(tcic_pkg::ADDR_CNT_LO, 8'h00);
    rd(tcic_pkg::ADDR_FLAGS, 8'h00, 8'h00);
    chk(timer_irq, 1'b0, "irq after clear");
    $display("test overflow done");
    wr(tcic_pkg::ADDR_CTRL_TWO, 8'h00);
    rd(tcic_pkg::ADDR_CNT_HI, 8'hFF, 8'h00);
    run_for(40);
    rd(tcic_pkg::ADDR_ALT_HI, 8'h00, 8'h00);
    rd(tcic_pkg::ADDR_CNT_LO, 8'hFC, 8'h00);
    rd(tcic_pkg::ADDR_CNT_LO, 8'h10, 8'h00);
    $display("test read buffer done");
    rd(tcic_pkg::ADDR_FLAGS, 8'h20, 8'h00);
    wr(tcic_pkg::ADDR_CNT_LO, 8'h00);
    wr(tcic_pkg::ADDR_CTRL_ONE, 8'h82);
    pins_to(1'b0, 1'b1);
    pins_to(1'b1, 1'b1);
    chk(timer_irq, 1'b1, "capture irq");
    rd(tcic_pkg::ADDR_FLAGS, 8'h80, 8'h00);
    rd(tcic_pkg::ADDR_CAP1_HI, 8'hFF, 8'h00);
    run_for(4);
    pins_to(1'b0, 1'b1);
    pins_to(1'b1, 1'b1);
    rd(tcic_pkg::ADDR_CAP1_LO, 8'hFC, 8'h00);
    rd(tcic_pkg::ADDR_FLAGS, 8'h00, 8'h00);
    chk(timer_irq, 1'b0, "irq after capture clear");
    pins_to(1'b0, 1'b1);
    cap1_lvl <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(timer_irq, 1'b0, "flag too early");
    repeat (1) @(posedge clk_sys);
    chk(timer_irq, 1'b1, "flag too late");
    rd(tcic_pkg::ADDR_FLAGS, 8'h80, 8'h00);
    rd(tcic_pkg::ADDR_CAP1_HI, 8'hFF, 8'h00);
    rd(tcic_pkg::ADDR_CAP1_LO, 8'hFE, 8'h00);
    for (k = 0; k < 2; k++) begin
      wr(tcic_pkg::ADDR_CTRL_TWO, (k == 0) ? 8'h40 : 8'h10);
      pins_to(1'b0, 1'b0);
      pins_to(1'b1, 1'b1);
      rd(tcic_pkg::ADDR_FLAGS, 8'h10, 8'h00);
      rd(tcic_pkg::ADDR_CAP2_HI, 8'hFF, 8'h00);
      rd(tcic_pkg::ADDR_CAP2_LO, 8'hFE, 8'h00);
    end
    $display("test capture done");
    foreach (zl[i]) begin
      if (i < 2) begin
        wr(tcic_pkg::ADDR_CTRL_TWO, 8'(8'h0D - i));
        wr(tcic_pkg::ADDR_CNT_LO, 8'h00);
        halt_mode <= 1'b0;
        ext_gap   <= 4'(3 + ($random(seed) & 3));
        ext_start <= 1'b1;
        @(posedge clk_sys);
        ext_start <= 1'b0;
        @(posedge clk_sys);
        for (k = 0; k < 400 && ext_busy !== 1'b0; k++) @(posedge clk_sys);
        if (k == 400) begin
          fail("external clock burst hung");
          end_of_test();
        end
        run_for(8);
        rd(tcic_pkg::ADDR_CNT_HI, 8'h00, 8'h00);
        rd(tcic_pkg::ADDR_CNT_LO, 8'h06, 8'h00);
      end
    end
    $display("test external clock done");
    end_of_test();
  end
endmodule : tb_timer_counter_with_input_capture
`default_nettype wire

// ==== verif/tcic_pin_model.sv ====
// Partner model: capture pin levels and a bursty external timer clock
`timescale 1ns/1ps
`default_nettype none
module tcic_pin_model (
  input  wire logic       clk_sys,
  input  wire logic       cap1_lvl,
  input  wire logic       cap2_lvl,
  input  wire logic       ext_start,
  input  wire logic [3:0] ext_gap,
  output logic            capture_pin_1,
  output logic            capture_pin_2,
  output logic            ext_timer_clock_pin,
  output logic            ext_busy
);
  int n_left;
  int ph;
  assign capture_pin_1 = cap1_lvl;
  assign capture_pin_2 = cap2_lvl;
  assign ext_busy      = (n_left != 0);
  initial begin
    n_left = 0;
    ph = 0;
    ext_timer_clock_pin = 1'b1;
  end
  // Burst of ten active edges of each kind, clock stands high between bursts
  always @(posedge clk_sys) begin
    if (ext_start && n_left == 0) begin
      n_left <= 20;
      ph     <= 0;
    end else if (n_left != 0) begin
      if (ph >= int'(ext_gap) - 1) begin
        ph                  <= 0;
        ext_timer_clock_pin <= ~ext_timer_clock_pin;
        n_left              <= n_left - 1;
      end else begin
        ph <= ph + 1;
      end
    end
  end
endmodule : tcic_pin_model
`default_nettype wire

// ==== verilog/tcic_pin_if.sv ====
// Interface: raw pin level and synchronised edge events between top and pin stage
`timescale 1ns/1ps
`default_nettype none
interface tcic_pin_if;
  logic raw;
  logic rise;
  logic fall;
  modport stage (input raw, output rise, output fall);
  modport user  (output raw, input rise, input fall);
endinterface : tcic_pin_if
`default_nettype wire

// ==== verilog/tcic_pin_sync.sv ====
// Module: two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module tcic_pin_sync (
  input  wire logic   clk_sys,
  input  wire logic   srst,
  tcic_pin_if.stage   pin
);
  typedef struct packed {
    logic [tcic_pkg::SYNC_STAGES-1:0] sync;
    logic                              last;
  } tcic_sync_type;

  tcic_sync_type st_r;
  tcic_sync_type st_nxt;

  // ----------------------------------------
  // Synchroniser and edge detect
  // ----------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.sync = {st_r.sync[0], pin.raw};                        // [RQ23]
    st_nxt.last = st_r.sync[1];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '1;                                                 // [RQ22]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin.rise = st_r.sync[1] & ~st_r.last;                     // [RQ23]
  assign pin.fall = ~st_r.sync[1] & st_r.last;

  a_edge_single: assert property (@(posedge clk_sys) disable iff (srst)
    pin.rise |=> !pin.rise) else $error("rise pulse lasted two cycles"); // [RQ23]
endmodule : tcic_pin_sync
`default_nettype wire

// ==== verilog/tcic_pkg.sv ====
// Package: register map, fields, reset values and timing for the capture timer
//
// Overview of operation
// [RQ1] Sixteen-bit up-counter wraps freely, one step per selected timer tick.
// [RQ2] Internal tick is clock divided by two, four or eight per clock select.
// [RQ3] Writing either counter low byte forces the count to FFFCh.
// [RQ4] Reset and every mode start the count at FFFCh, the only reload value.
// [RQ5] Both counter views read alike; alternate low byte never clears overflow.
// [RQ6] High byte read buffers low byte, held until the low byte is read.
// [RQ7] After a completed pair, a lone low byte read returns the live low byte.
// [RQ8] Overflow flag sets whenever the count passes FFFFh to 0000h.
// [RQ9] Overflow requests interrupt when enabled and unmasked, else stays pending.
// [RQ10] Overflow flag clears by status read seeing it, then main low byte access.
// [RQ11] Wait has no effect; halt freezes the count, resuming from held value.
// [RQ12] Both clock select bits high pick the external pin; edge bit picks edge.
// [RQ13] External clock events are synchronised before advancing the count.
// [RQ14] External source leaves four clock edges between active edges.
// [RQ15] Each capture channel latches the count on its selected pin edge.
// [RQ16] Capture sets its flag; shared enable and mask gate the interrupt.
// [RQ17] Capture flag clears by status read seeing it, then its low byte access.
// [RQ18] Capture high byte read blocks captures and flag until low byte read.
// [RQ19] In one-pulse or PWM mode only capture channel two captures.
// [RQ20] Capture pins always reach the capture logic, whatever their direction.
// [RQ21] Capture flag sets two to three clock cycles after the pin event; the code sets it on the fourth clock edge after the pin change.
// [RQ22] An unbonded timer input reads as logic one.
// [RQ23] Pins pass a two-stage synchroniser before edge detection.
package tcic_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [5:0] ADDR_CTRL_ONE  = 6'h00;
  localparam logic [5:0] ADDR_CTRL_TWO  = 6'h04;
  localparam logic [5:0] ADDR_FLAGS     = 6'h08;
  localparam logic [5:0] ADDR_CAP1_HI   = 6'h0C;
  localparam logic [5:0] ADDR_CAP1_LO   = 6'h10;
  localparam logic [5:0] ADDR_CNT_HI    = 6'h14;
  localparam logic [5:0] ADDR_CNT_LO    = 6'h18;
  localparam logic [5:0] ADDR_ALT_HI    = 6'h1C;
  localparam logic [5:0] ADDR_ALT_LO    = 6'h20;
  localparam logic [5:0] ADDR_CAP2_HI   = 6'h24;
  localparam logic [5:0] ADDR_CAP2_LO   = 6'h28;

  // ----------------------------------------
  // Control register one fields
  // ----------------------------------------
  localparam int CR1_CAP_IRQ_EN  = 7;
  localparam int CR1_OVF_IRQ_EN  = 5;
  localparam int CR1_EDGE_ONE    = 1;
  // ----------------------------------------
  // Control register two fields
  // ----------------------------------------
  localparam int CR2_ONE_PULSE   = 6;
  localparam int CR2_PWM         = 4;
  localparam int CR2_CLK_SEL_HI  = 3;
  localparam int CR2_CLK_SEL_LO  = 2;
  localparam int CR2_EDGE_TWO    = 1;
  localparam int CR2_EXT_EDGE    = 0;
  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int SR_CAP_ONE      = 7;
  localparam int SR_OVF          = 5;
  localparam int SR_CAP_TWO      = 4;

  // ----------------------------------------
  // Reset values and selects
  // ----------------------------------------
  localparam logic [15:0] COUNT_RESET   = 16'hFFFC;
  localparam logic [15:0] COUNT_TOP     = 16'hFFFF;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [15:0] CAP_RESET     = 16'h0000;
  localparam logic [1:0]  CLK_SEL_DIV2  = 2'h0;
  localparam logic [1:0]  CLK_SEL_DIV4  = 2'h1;
  localparam logic [1:0]  CLK_SEL_DIV8  = 2'h2;
  localparam logic [1:0]  CLK_SEL_EXT   = 2'h3;
  localparam int          SYNC_STAGES   = 2;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } tcic_bus_type;

endpackage : tcic_pkg

// ==== verilog/tcic_timer.sv ====
// Module: sixteen-bit timer with prescaler, external clock and two captures
`timescale 1ns/1ps
`default_nettype none
module tcic_timer (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        capture_pin_1,
  input  wire logic        capture_pin_2,
  input  wire logic        ext_timer_clock_pin,
  input  wire logic        cpu_irq_mask,
  input  wire logic        halt_mode,
  output logic             timer_irq
);

  typedef struct packed {
    tcic_pkg::tcic_bus_type bus;
    logic [31:0]            rdata;
    logic [7:0]             ctrl_one;
    logic [7:0]             ctrl_two;
    logic [15:0]            count;
    logic [2:0]             presc;
    logic                   ovf;
    logic                   ovf_seen;
    logic                   cap1_flag;
    logic                   cap2_flag;
    logic                   cap1_seen;
    logic                   cap2_seen;
    logic                   cap1_block;
    logic                   cap2_block;
    logic [15:0]            cap1;
    logic [15:0]            cap2;
    logic [7:0]             lo_buf;
    logic                   lo_held;
    logic                   ext_pend;
    logic                   cap1_pend;
    logic                   cap2_pend;
  } tcic_state_type;

  tcic_state_type st_r;
  tcic_state_type st_nxt;

  tcic_pin_if cap1_if ();
  tcic_pin_if cap2_if ();
  tcic_pin_if ext_if ();

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign cap1_if.raw = capture_pin_1;                              // [RQ20]
  assign cap2_if.raw = capture_pin_2;                              // [RQ20]
  assign ext_if.raw  = ext_timer_clock_pin;

  tcic_pin_sync u_sync_cap1 (.clk_sys(clk_sys), .srst(srst), .pin(cap1_if.stage));
  tcic_pin_sync u_sync_cap2 (.clk_sys(clk_sys), .srst(srst), .pin(cap2_if.stage));
  tcic_pin_sync u_sync_ext  (.clk_sys(clk_sys), .srst(srst), .pin(ext_if.stage));

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  logic [1:0] clk_sel;
  logic       ext_evt;
  logic       cap1_evt;
  logic       cap2_evt;
  logic       tick;
  logic       ovf_evt;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       rd_go;
  logic       pwm_or_opm;
  logic [7:0] status;

  assign clk_sel    = {st_r.ctrl_two[tcic_pkg::CR2_CLK_SEL_HI],
                       st_r.ctrl_two[tcic_pkg::CR2_CLK_SEL_LO]};
  assign pwm_or_opm = st_r.ctrl_two[tcic_pkg::CR2_ONE_PULSE] |
                      st_r.ctrl_two[tcic_pkg::CR2_PWM];
  assign ext_evt    = st_r.ctrl_two[tcic_pkg::CR2_EXT_EDGE] ? ext_if.rise
                                                             : ext_if.fall; // [RQ12]
  assign cap1_evt   = st_r.ctrl_one[tcic_pkg::CR1_EDGE_ONE] ? cap1_if.rise
                                                             : cap1_if.fall; // [RQ15]
  assign cap2_evt   = st_r.ctrl_two[tcic_pkg::CR2_EDGE_TWO] ? cap2_if.rise
                                                             : cap2_if.fall; // [RQ15]

  // Timer tick: prescaler terminal count or synchronised external edge
  always_comb begin
    case (clk_sel)                                                 // [RQ2]
      tcic_pkg::CLK_SEL_DIV2: tick = (st_r.presc[0] == 1'b1);
      tcic_pkg::CLK_SEL_DIV4: tick = (st_r.presc[1:0] == 2'h3);
      tcic_pkg::CLK_SEL_DIV8: tick = (st_r.presc == 3'h7);
      tcic_pkg::CLK_SEL_EXT:  tick = st_r.ext_pend;                // [RQ12] [RQ13]
      default:                tick = 1'b0;
    endcase
    tick = tick & ~halt_mode;                                      // [RQ11]
  end

  assign ovf_evt = tick && (st_r.count == tcic_pkg::COUNT_TOP);    // [RQ8]
  assign acc     = (st_r.bus == tcic_pkg::BUS_ACK);
  assign wr      = acc & avs_write;
  assign rd      = acc & avs_read;
  assign rd_go   = (st_r.bus == tcic_pkg::BUS_IDLE) & avs_read;

  assign status = {st_r.cap1_flag, 1'b0, st_r.ovf, st_r.cap2_flag, 4'h0};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.ext_pend  = ext_evt;                                    // [RQ13]
    st_nxt.cap1_pend = cap1_evt & ~pwm_or_opm;                     // [RQ19] [RQ21]
    st_nxt.cap2_pend = cap2_evt;                                   // [RQ21]
    st_nxt.presc     = halt_mode ? st_r.presc : st_r.presc + 3'h1; // [RQ11]

    // Bus handshake: one wait cycle then acknowledge
    case (st_r.bus)
      tcic_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          st_nxt.bus = tcic_pkg::BUS_ACK;
        end
      end
      tcic_pkg::BUS_ACK: begin
        st_nxt.bus = tcic_pkg::BUS_IDLE;
      end
      default: begin
        st_nxt.bus = tcic_pkg::BUS_IDLE;
      end
    endcase

    if (tick) begin
      st_nxt.count = st_r.count + 16'h0001;                        // [RQ1]
    end

    // Status snapshot arms the two-step clears
    if (rd && avs_address == tcic_pkg::ADDR_FLAGS) begin
      st_nxt.ovf_seen  = st_r.rdata[tcic_pkg::SR_OVF];
      st_nxt.cap1_seen = st_r.rdata[tcic_pkg::SR_CAP_ONE];
      st_nxt.cap2_seen = st_r.rdata[tcic_pkg::SR_CAP_TWO];
    end

    // Read data is registered as the request is taken, so it stands in the ack cycle
    st_nxt.rdata = 32'h0000_0000;
    if (acc || rd_go) begin
      case (avs_address)
        tcic_pkg::ADDR_CTRL_ONE: begin
          st_nxt.rdata[7:0] = st_r.ctrl_one;
          if (wr) begin
            st_nxt.ctrl_one = avs_writedata[7:0];
          end
        end
        tcic_pkg::ADDR_CTRL_TWO: begin
          st_nxt.rdata[7:0] = st_r.ctrl_two;
          if (wr) begin
            st_nxt.ctrl_two = avs_writedata[7:0];
          end
        end
        tcic_pkg::ADDR_FLAGS: st_nxt.rdata[7:0] = status;
        tcic_pkg::ADDR_CNT_HI, tcic_pkg::ADDR_ALT_HI: begin
          st_nxt.rdata[7:0] = st_r.count[15:8];
          if (rd_go && !st_r.lo_held) begin
            st_nxt.lo_buf  = st_r.count[7:0];                       // [RQ6]
            st_nxt.lo_held = 1'b1;
          end
        end
        tcic_pkg::ADDR_CNT_LO, tcic_pkg::ADDR_ALT_LO: begin
          st_nxt.rdata[7:0] = st_r.lo_held ? st_r.lo_buf : st_r.count[7:0]; // [RQ7]
          if (rd) begin
            st_nxt.lo_held = 1'b0;                                  // [RQ6]
          end
          if (wr) begin
            st_nxt.count   = tcic_pkg::COUNT_RESET;                 // [RQ3] [RQ4]
            st_nxt.lo_held = 1'b0;
          end
          if (acc && avs_address == tcic_pkg::ADDR_CNT_LO && st_r.ovf_seen) begin
            st_nxt.ovf      = 1'b0;                                 // [RQ10] [RQ5]
            st_nxt.ovf_seen = 1'b0;
          end
        end
        tcic_pkg::ADDR_CAP1_HI: begin
          st_nxt.rdata[7:0] = st_r.cap1[15:8];
          if (rd_go) begin
            st_nxt.cap1_block = 1'b1;                               // [RQ18]
          end
        end
        tcic_pkg::ADDR_CAP1_LO: begin
          st_nxt.rdata[7:0] = st_r.cap1[7:0];
          if (rd) begin
            st_nxt.cap1_block = 1'b0;                               // [RQ18]
          end
          if (acc && st_r.cap1_seen) begin
            st_nxt.cap1_flag = 1'b0;                                // [RQ17]
            st_nxt.cap1_seen = 1'b0;
          end
        end
        tcic_pkg::ADDR_CAP2_HI: begin
          st_nxt.rdata[7:0] = st_r.cap2[15:8];
          if (rd_go) begin
            st_nxt.cap2_block = 1'b1;                               // [RQ18]
          end
        end
        tcic_pkg::ADDR_CAP2_LO: begin
          st_nxt.rdata[7:0] = st_r.cap2[7:0];
          if (rd) begin
            st_nxt.cap2_block = 1'b0;                               // [RQ18]
          end
          if (acc && st_r.cap2_seen) begin
            st_nxt.cap2_flag = 1'b0;                                // [RQ17]
            st_nxt.cap2_seen = 1'b0;
          end
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Hardware sets win over software clears
    if (ovf_evt) begin
      st_nxt.ovf = 1'b1;                                           // [RQ8]
    end
    if (st_r.cap1_pend && !st_nxt.cap1_block) begin
      st_nxt.cap1      = st_r.count;                               // [RQ15]
      st_nxt.cap1_flag = 1'b1;                                     // [RQ16]
    end
    if (st_r.cap2_pend && !st_nxt.cap2_block) begin
      st_nxt.cap2      = st_r.count;                               // [RQ15]
      st_nxt.cap2_flag = 1'b1;                                     // [RQ16]
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r          <= '0;
      st_r.bus      <= tcic_pkg::BUS_IDLE;
      st_r.count    <= tcic_pkg::COUNT_RESET;                      // [RQ4]
      st_r.ctrl_one <= tcic_pkg::CTRL_RESET;
      st_r.ctrl_two <= tcic_pkg::CTRL_RESET;
      st_r.cap1     <= tcic_pkg::CAP_RESET;
      st_r.cap2     <= tcic_pkg::CAP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata    = st_r.rdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~acc;
  assign timer_irq       = ~cpu_irq_mask & (                        // [RQ9] [RQ16]
                           (st_r.ovf & st_r.ctrl_one[tcic_pkg::CR1_OVF_IRQ_EN]) |
                           ((st_r.cap1_flag | st_r.cap2_flag) &
                            st_r.ctrl_one[tcic_pkg::CR1_CAP_IRQ_EN]));

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_count_wrap: assert property (@(posedge clk_sys) disable iff (srst)
    ovf_evt |=> (st_r.count == 16'h0000) && st_r.ovf)               // [RQ8]
    else $error("overflow did not wrap and flag");
  a_count_step: assert property (@(posedge clk_sys) disable iff (srst)
    (tick && !wr) |=> st_r.count == $past(st_r.count) + 16'h0001)     // [RQ1]
    else $error("count did not advance on tick");
  a_div_two: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_sel == tcic_pkg::CLK_SEL_DIV2 && !halt_mode && tick) |=> !tick) // [RQ2]
    else $error("divide by two ticked twice");
  a_low_write: assert property (@(posedge clk_sys) disable iff (srst)
    (wr && avs_address == tcic_pkg::ADDR_ALT_LO) |=> st_r.count == 16'hFFFC) // [RQ3]
    else $error("low write did not reload");
  a_alt_keeps: assert property (@(posedge clk_sys) disable iff (srst)
    (acc && avs_address == tcic_pkg::ADDR_ALT_LO && st_r.ovf) |=> st_r.ovf) // [RQ5]
    else $error("alternate low access cleared overflow");
  a_halt_hold: assert property (@(posedge clk_sys) disable iff (srst)
    (halt_mode && !wr) |=> $stable(st_r.count))                     // [RQ11]
    else $error("count moved in halt");
  a_cap_block: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.cap1_block && !st_r.cap1_flag && !rd) |=> !st_r.cap1_flag) // [RQ18]
    else $error("blocked capture set flag");
  a_cap_delay: assert property (@(posedge clk_sys) disable iff (srst)
    (cap2_evt && !st_r.cap2_block && !avs_read && !avs_write) ##1 !avs_read
    |=> st_r.cap2_flag)                                              // [RQ21]
    else $error("capture flag not set in time");
  a_opm_cap: assert property (@(posedge clk_sys) disable iff (srst)
    (pwm_or_opm && $stable(pwm_or_opm) && !st_r.cap1_flag) |=> !st_r.cap1_flag) // [RQ19]
    else $error("channel one captured in pulse mode");
  a_irq_mask: assert property (@(posedge clk_sys) disable iff (srst)
    cpu_irq_mask |-> !timer_irq)                                    // [RQ9]
    else $error("interrupt passed mask");
  a_ovf_keep: assert property (@(posedge clk_sys) disable iff (srst) // [RQ10]
    (st_r.ovf && !(acc && avs_address == tcic_pkg::ADDR_CNT_LO)) |=> st_r.ovf)
    else $error("overflow cleared without low access");
  a_one_wait: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.bus == tcic_pkg::BUS_IDLE && (avs_read || avs_write)) |=> acc)
    else $error("request not acknowledged after one wait");

  c_overflow: cover property (@(posedge clk_sys) disable iff (srst) ovf_evt);
  c_capture:  cover property (@(posedge clk_sys) disable iff (srst)
    st_r.cap2_pend && !st_r.cap2_block);
  c_ext_tick: cover property (@(posedge clk_sys) disable iff (srst)
    clk_sel == tcic_pkg::CLK_SEL_EXT && tick);
  c_hi_lo:    cover property (@(posedge clk_sys) disable iff (srst)
    rd && avs_address == tcic_pkg::ADDR_CNT_LO && st_r.lo_held);

endmodule : tcic_timer
`default_nettype wire
